// file: core/misc_event_mask_sense.sv
/*
  Miscellaneous event interrupt logic: latched status, mask and live sense
  registers for five power-management events, and the active-low interrupt.
  Assumes a simple synchronous 8-bit register port on sys_clk and event
  levels that arrive from analog or other-clock logic.
  Read and write strobes are single-cycle pulses; read data stands for
  one cycle after the read edge and reads zero otherwise.
  Writes to the sense register and to unused offsets are ignored.
  An event level needs three edges to reach its status flag, and the
  interrupt pin follows the status one edge later.
  Reset is synchronous, so sys_clk must run while rst_b is low.
*/
// Function
// [RQ1] Status bit clears on read or write-one.
// [RQ2] Mask zero lets set status pull interrupt.
// [RQ3] Mask one blocks that status from interrupt.
// [RQ4] Mask bit 0 wake-done, resets 1, async set; code sets it on a sys_clk edge after sync.
// [RQ5] Mask bit 1 sleep-done, resets to one.
// [RQ6] Mask bit 2 button event, resets one.
// [RQ7] Mask bit 3 supply-low warning, resets one.
// [RQ8] Mask bit 4 overvoltage; bits 7..5 unused.
// [RQ9] Sense bits 0,1 show transitions in progress.
// [RQ10] Sense bit 2 follows button input level.
// [RQ11] Sense bit 3 shows supply below warning.
// [RQ12] Sense bit 4 shows overvoltage; upper unused.
// [RQ13] Status latches wake, sleep, button events.
// [RQ14] Status latches supply low, overvoltage crossings.
// [RQ15] Interrupt is OR of unmasked status, low.
`timescale 1ns/10ps
`default_nettype none
module misc_event_mask_sense
  import misc_event_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Register access port.
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Event levels from the power sequencer and comparators.
  input  wire logic       wake_in_progress,
  input  wire logic       sleep_in_progress,
  input  wire logic       power_button_input,
  input  wire logic       supply_low_threshold,
  input  wire logic       supply_over_threshold,
  // Asynchronous request to set the wake-done mask bit.
  input  wire logic       wake_mask_set,
  // Interrupt to the host, active low.
  output logic            irq_out_n
);

  // Event levels, raw and after the synchronisers.
  logic [EVENT_COUNT-1:0] level_raw;
  logic [EVENT_COUNT-1:0] level_sync;
  logic [EVENT_COUNT-1:0] rise_pulse;
  // Register state and next values.
  logic [EVENT_COUNT-1:0] status_reg;
  logic [EVENT_COUNT-1:0] status_next;
  logic [EVENT_COUNT-1:0] mask_reg;
  logic [EVENT_COUNT-1:0] mask_next;
  logic [EVENT_COUNT-1:0] sense_reg;
  logic [EVENT_COUNT-1:0] sense_next;
  logic [EVENT_COUNT-1:0] event_set;
  logic [7:0]             rdata_reg;
  logic [7:0]             rdata_next;
  logic                   irq_n_reg;
  logic                   irq_n_next;
  logic                   wake_set_rise;
  // Decoded register strobes.
  logic                   status_read;
  logic                   status_write;
  logic                   mask_write;

  // Decodes a register offset against the port address.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction : hit

  // Gather the event levels in status-bit order.
  assign level_raw = {supply_over_threshold, supply_low_threshold, power_button_input,
                      sleep_in_progress, wake_in_progress};

  // Synchronise every event level before any logic reads it.
  genvar gi;
  generate
    for (gi = 0; gi < EVENT_COUNT; gi++) begin : g_sync
      event_edge_sync u_sync (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .level_in   (level_raw[gi]),
        .level_sync (level_sync[gi]),
        .rise_pulse (rise_pulse[gi])
      );
    end
  endgenerate

  // The mask set request is a pin from outside, so it is synchronised too.
  event_edge_sync u_mask_set_sync (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .level_in   (wake_mask_set),
    .level_sync (),
    .rise_pulse (wake_set_rise)
  );

  // Transitions latch on completion (falling in-progress), comparators on entry.
  always_comb begin
    event_set                   = rise_pulse;
    // Transition flags fire when the in-progress level drops.
    event_set[WAKE_DONE_BIT]    = sense_reg[WAKE_DONE_BIT] & ~level_sync[WAKE_DONE_BIT]; // RQ13
    event_set[SLEEP_DONE_BIT]   = sense_reg[SLEEP_DONE_BIT] & ~level_sync[SLEEP_DONE_BIT]; // RQ13
    // The button flag fires on either edge of its level.
    event_set[BUTTON_EVENT_BIT] = sense_reg[BUTTON_EVENT_BIT] ^ level_sync[BUTTON_EVENT_BIT]; // RQ13
    event_set[SUPPLY_LOW_BIT]   = rise_pulse[SUPPLY_LOW_BIT]; // RQ14
    event_set[SUPPLY_OVER_BIT]  = rise_pulse[SUPPLY_OVER_BIT]; // RQ14
  end

  // Address-qualified strobes, shared by the status and mask groups.
  // A read and a write in one cycle both take effect.
  assign status_read  = reg_rd & hit(reg_addr, STATUS_OFFSET);
  assign status_write = reg_wr & hit(reg_addr, STATUS_OFFSET);
  assign mask_write   = reg_wr & hit(reg_addr, MASK_OFFSET);

  // Status: a read clears every flag, a write of one clears that flag.
  always_comb begin
    status_next = status_reg;
    if (status_read) begin
      status_next = '0; // RQ1
    end
    if (status_write) begin
      status_next = status_next & ~reg_wdata[EVENT_COUNT-1:0]; // RQ1
    end
    // A flag that sets in the cycle it is cleared stays set, so no event is lost.
    status_next = status_next | event_set; // RQ13 RQ14
    if (!rst_b) begin
      status_next = STATUS_RESET;
    end
  end

  // Register the status flags.
  always_ff @(posedge sys_clk) begin
    status_reg <= status_next;
  end

  // Mask: a host write stores the bits; the external request sets bit 0.
  always_comb begin
    mask_next = mask_reg;
    if (mask_write) begin
      mask_next = reg_wdata[EVENT_COUNT-1:0]; // RQ5 RQ6 RQ7 RQ8
    end
    // The external set wins over a host write of zero in the same cycle.
    if (wake_set_rise) begin
      mask_next[WAKE_DONE_BIT] = 1'b1; // RQ4
    end
    if (!rst_b) begin
      mask_next = MASK_RESET; // RQ4 RQ5 RQ6 RQ7 RQ8
    end
  end

  // Register the mask bits.
  always_ff @(posedge sys_clk) begin
    mask_reg <= mask_next;
  end

  // Sense: the synchronised levels, held one edge so reads see a settled value.
  always_comb begin
    sense_next = level_sync; // RQ9 RQ10 RQ11 RQ12
    if (!rst_b) begin
      sense_next = SENSE_RESET;
    end
  end

  // Register the sense bits; they also serve as the previous level for edges.
  always_ff @(posedge sys_clk) begin
    sense_reg <= sense_next;
  end

  // Read data: the addressed register for one cycle, zero otherwise.
  always_comb begin
    rdata_next = 8'h00;
    // Unused offsets and the unused upper bits read as zero.
    if (reg_rd) begin
      if (hit(reg_addr, STATUS_OFFSET)) begin
        rdata_next = {3'h0, status_reg}; // RQ13 RQ14
      end else if (hit(reg_addr, MASK_OFFSET)) begin
        rdata_next = {3'h0, mask_reg}; // RQ8
      end else if (hit(reg_addr, SENSE_OFFSET)) begin
        rdata_next = {3'h0, sense_reg}; // RQ12
      end
    end
    if (!rst_b) begin
      rdata_next = 8'h00;
    end
  end

  // Register the read data.
  always_ff @(posedge sys_clk) begin
    rdata_reg <= rdata_next;
  end

  // Interrupt: low while any set status bit has its mask cleared.
  always_comb begin
    // The pin is released one edge after no unmasked flag remains.
    irq_n_next = ~|(status_reg & ~mask_reg); // RQ2 RQ3 RQ15
    if (!rst_b) begin
      irq_n_next = 1'b1;
    end
  end

  // Register the interrupt level so the pin cannot glitch between edges.
  always_ff @(posedge sys_clk) begin
    irq_n_reg <= irq_n_next;
  end

  // Drive the outputs straight from their registers.
  assign reg_rdata = rdata_reg;
  assign irq_out_n = irq_n_reg;

endmodule : misc_event_mask_sense
`default_nettype wire

// file: core/misc_event_pkg.sv
/*
  Constants for the miscellaneous event interrupt block: register offsets,
  field positions and values after reset.
  Assumes an 8-bit register access port with 8-bit addresses.
*/
package misc_event_pkg;

  localparam int          EVENT_COUNT        = 5;
  localparam logic [7:0]  STATUS_OFFSET      = 8'h28;
  localparam logic [7:0]  MASK_OFFSET        = 8'h29;
  localparam logic [7:0]  SENSE_OFFSET       = 8'h2A;

  localparam int          WAKE_DONE_BIT      = 0;
  localparam int          SLEEP_DONE_BIT     = 1;
  localparam int          BUTTON_EVENT_BIT   = 2;
  localparam int          SUPPLY_LOW_BIT     = 3;
  localparam int          SUPPLY_OVER_BIT    = 4;

  localparam logic [4:0]  STATUS_RESET       = 5'h00;
  localparam logic [4:0]  MASK_RESET         = 5'h1F;
  localparam logic [4:0]  SENSE_RESET        = 5'h00;
  localparam logic [1:0]  SYNC_RESET         = 2'h0;

endpackage : misc_event_pkg

// file: core/event_edge_sync.sv
/*
  Two-flop synchroniser for one external level, with a rising-edge pulse
  taken from the synchronised level.
  Assumes the level comes from outside the sys_clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module event_edge_sync
  import misc_event_pkg::*;
(
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Level in and conditioned results out.
  input  wire logic level_in,
  output logic      level_sync,
  output logic      rise_pulse
);

  logic [1:0] sync_reg;
  logic [1:0] sync_next;
  logic       last_reg;
  logic       last_next;

  // Shift the level through both stages; only the second stage is looked at.
  always_comb begin
    sync_next = {sync_reg[0], level_in};
    last_next = sync_reg[1];
    if (!rst_b) begin
      sync_next = SYNC_RESET;
      last_next = 1'b0;
    end
  end

  // Register the synchroniser state.
  always_ff @(posedge sys_clk) begin
    sync_reg <= sync_next;
    last_reg <= last_next;
  end

  // Present the clean level and its rising edge.
  assign level_sync = sync_reg[1];
  assign rise_pulse = sync_reg[1] & ~last_reg;

endmodule : event_edge_sync
`default_nettype wire

// file: testbench/misc_event_checker_assertions.sv
/* Port checker for misc_event_mask_sense.
   Assumes it is bound to that module and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module misc_event_checker (
  input wire logic       sys_clk, rst_b, reg_wr, reg_rd, irq_out_n,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic       wake_in_progress, sleep_in_progress, power_button_input,
  input wire logic       supply_low_threshold, supply_over_threshold, wake_mask_set
);
  logic [4:0] ev, ev_d;
  logic [2:0] calm;
  // Event levels gathered in status-bit order.
  assign ev = {supply_over_threshold, supply_low_threshold, power_button_input,
               sleep_in_progress, wake_in_progress};
  // Counts edges since the levels last moved, saturating at 7.
  always_ff @(posedge sys_clk) begin
    ev_d <= ev;
    calm <= (!rst_b || ev != ev_d) ? 3'h0 : calm + {2'h0, calm != 3'h7};
  end
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_irq_reset: assert property ($rose(rst_b) |-> irq_out_n) else $error("irq low");
  a_rdata_upper: assert property (reg_rd |=> reg_rdata[7:5] == 3'h0) else $error("upper");
  a_sense_live: assert property (reg_rd && reg_addr == 8'h2A && calm == 3'h7
    |=> reg_rdata == {3'h0, $past(ev)}) else $error("sense");
  a_read_clear: assert property (reg_rd && reg_addr == 8'h28 && calm == 3'h7
    |=> ##1 irq_out_n) else $error("read clear");
  a_w1c_clear: assert property (reg_wr && reg_addr == 8'h28 && reg_wdata == 8'hFF
    && calm == 3'h7 |=> ##1 irq_out_n) else $error("w1c");
  a_mask_block: assert property (reg_wr && reg_addr == 8'h29 && reg_wdata == 8'hFF
    && calm == 3'h7 |=> ##1 irq_out_n) else $error("mask");
  a_irq_rise: assert property ($rose(irq_out_n) |-> $past(reg_rd || reg_wr)
    || $past(reg_rd || reg_wr, 2)
    || ($past(wake_mask_set, 4) && !$past(wake_mask_set, 5))) else $error("rise");
  a_irq_fall: assert property ($fell(irq_out_n) |-> calm != 3'h7
    || $past(reg_wr) || $past(reg_wr, 2)) else $error("fall");
  c_read: cover property (reg_rd && reg_addr == 8'h28);
  c_fall: cover property ($fell(irq_out_n));
  c_mask: cover property (reg_wr && reg_addr == 8'h29);
endmodule : misc_event_checker
bind misc_event_mask_sense misc_event_checker misc_event_checker_inst (
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .irq_out_n(irq_out_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .wake_in_progress(wake_in_progress), .sleep_in_progress(sleep_in_progress),
  .power_button_input(power_button_input), .supply_low_threshold(supply_low_threshold),
  .supply_over_threshold(supply_over_threshold), .wake_mask_set(wake_mask_set));
`default_nettype wire

// file: testbench/reg_host.sv
/* Processor model on the register port.
   Assumes one caller process; requests launch off the falling edge. */
`timescale 1ns/10ps
`default_nettype none
module reg_host (
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  output var  logic [7:0] reg_addr, reg_wdata,
  output var  logic       reg_wr, reg_rd
);
  // Idle port after time zero.
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
  end
  // One write strobe; address and data scrambled once released.
  task automatic wr(input logic [7:0] a, d);
    @(negedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
  endtask : wr
  // One read strobe; data taken in the cycle that it stands.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge sys_clk);
    {reg_rd, reg_addr} = {1'b0, ~a};
    d = reg_rdata;
  endtask : rd
endmodule : reg_host
`default_nettype wire

// file: testbench/tb_misc_event_mask_sense.sv
/* Self-checking bench for misc_event_mask_sense.
   Assumes reg_host as the processor side. */
`timescale 1ns/10ps
`default_nettype none
module tb_misc_event_mask_sense;
  logic       sys_clk = 1'b0, rst_b = 1'b0, wms = 1'b0, reg_wr, reg_rd, irq_out_n;
  logic [4:0] evs = 5'h00;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  int         miscompares = 0, checked = 0;
  // Clock of 5 ns period.
  always #2.5 sys_clk = ~sys_clk;
  reg_host reg_host_inst (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  misc_event_mask_sense misc_event_mask_sense_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .wake_in_progress(evs[0]), .sleep_in_progress(evs[1]),
    .power_button_input(evs[2]), .supply_low_threshold(evs[3]),
    .supply_over_threshold(evs[4]), .wake_mask_set(wms), .irq_out_n(irq_out_n));
  // Waits whole cycles, ending after a falling edge.
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  // Compares one byte and reports a difference.
  task automatic chk(input logic [7:0] g, e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // Reads one register and compares it.
  task automatic rc(input logic [7:0] a, e);
    reg_host_inst.rd(a, d);
    chk(d, e);
  endtask : rc
  // Prints the verdict and ends the run.
  task automatic give_verdict;
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // Reset values, live sense, per-event interrupts, clears, the async mask set, a mid-run reset.
  initial begin
    cyc(2);
    rst_b = 1'b1;
    rc(8'h28, 8'h00);
    rc(8'h29, 8'h1F);
    rc(8'h2A, 8'h00);
    rc(8'h2B, 8'h00);
    evs = 5'h1F;
    cyc(8);
    rc(8'h2A, 8'h1F);
    evs = 5'h00;
    cyc(8);
    rc(8'h2A, 8'h00);
    chk({7'h00, irq_out_n}, 8'h01);
    rc(8'h28, 8'h1F);
    rc(8'h28, 8'h00);
    for (int i = 0; i < 5; i++) begin
      reg_host_inst.wr(8'h29, ~(8'h01 << i));
      rc(8'h29, 8'h1F ^ (8'h01 << i));
      evs[i] = 1'b1;
      cyc(6);
      evs[i] = 1'b0;
      cyc(8);
      chk({7'h00, irq_out_n}, 8'h00);
      reg_host_inst.wr(8'h29, 8'hFF);
      cyc(2);
      chk({7'h00, irq_out_n}, 8'h01);
      reg_host_inst.wr(8'h28, 8'h1F ^ (8'h01 << i));
      rc(8'h28, 8'h01 << i);
      reg_host_inst.wr(8'h29, 8'h00);
      cyc(2);
      chk({7'h00, irq_out_n}, 8'h01);
    end
    evs[3] = 1'b1;
    cyc(8);
    chk({7'h00, irq_out_n}, 8'h00);
    reg_host_inst.wr(8'h28, 8'hFF);
    rc(8'h28, 8'h00);
    chk({7'h00, irq_out_n}, 8'h01);
    wms = 1'b1;
    cyc(6);
    rc(8'h29, 8'h01);
    reg_host_inst.wr(8'h29, 8'h00);
    evs[4] = 1'b1;
    cyc(8);
    chk({7'h00, irq_out_n}, 8'h00);
    evs = 5'h00;
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    chk({7'h00, irq_out_n}, 8'h01);
    rc(8'h28, 8'h00);
    rc(8'h29, 8'h1F);
    give_verdict();
  end
endmodule : tb_misc_event_mask_sense
`default_nettype wire
